// ---- stsv_status_tabler_supervisor.sv ----
// Status tabler supervisor: watchdog, suspension, commands, trace words
// Contract
// - Time the selected channel's status store; time out after 4 ms.
// - On timeout pulse selective reset to the offending channel.
// - On timeout log channel number, set timeout flag, stop tabling.
// - Suspend on tabling errors, pre-store errors, or tabler machine check.
// - While suspended ignore status requests from every channel.
// - On error suspension record cause in service word and raise interrupt.
// - Channel service error logs channel number and sets its flag.
// - Own tabling errors set data, word or table fault flag.
// - Logged channel number is the currently selected channel.
// - Only start-I/O cancels suspension; normal processing resumes.
// - Tabling handles 16,383 words total, at most three per unit.
// - Trace start-I/O only when trace bit set and port not excluded; an interface timeout stores its 3-word word without either check.
// - Traced start-I/O stores one-word trace word, no interrupt.
// - Interface timeout during start-I/O stores 3-word word, interrupts.
// - Halt-I/O suspends; start-I/O or unit reset clears it.
// - Halt-I/O answers 00 when normal, 11 when already suspended.
// - On cancellation clear bits 24..31 of the word, no address.
// - Start-I/O answers 00 and clears when suspended, else 11.
// - After storing an interrupt word raise tabler interrupt.
`timescale 1ns/10ps
`default_nettype none
module stsv_status_tabler_supervisor
	import stsv_pkg::*;
#(
	parameter int NUM_CH = 4,
	parameter int TIMEOUT_CYC = STORE_TIMEOUT_CYC,
	parameter int WORD_LIMIT = MAX_TABLE_WORDS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_CH-1:0] status_request,
	input wire logic [NUM_CH-1:0] store_done,
	input wire logic [NUM_CH-1:0] buffered_word_service_error,
	input wire stsv_err_t tabling_error,
	input wire logic [1:0] words_in_unit,
	input wire logic unit_done,
	input wire logic interface_timeout,
	output logic [NUM_CH-1:0] channel_grant,
	output logic [NUM_CH-1:0] selective_channel_reset,
	output logic tabler_irq,
	output logic trace_store,
	output logic [1:0] trace_words
);
	localparam int CHW = $clog2(NUM_CH);
	localparam int TW = $clog2(TIMEOUT_CYC + 1);

	initial begin
		if (NUM_CH < 2 || NUM_CH > 16 || TIMEOUT_CYC < 1 ||
			WORD_LIMIT < 1 || WORD_LIMIT > MAX_TABLE_WORDS)
			$error("stsv: unsupported parameter value");
	end

	stsv_state_t state_q;
	logic [TW-1:0] timer_q;
	logic [CHW-1:0] sel_ch_q;
	logic [31:0] ctrl_q;
	logic [31:0] service_q;
	logic [31:0] result_q;
	logic [31:0] trace_q;
	logic [13:0] words_q;
	logic [31:0] word_d;
	logic wr_en;
	logic rd_en;
	logic cmd_sio;
	logic cmd_hio;
	logic susp;
	logic timeout_hit;
	logic cse_hit;
	logic err_hit;
	logic any_err;
	logic [CHW-1:0] pick;
	logic pick_ok;
	logic trace_ok;
	// Reads have no side effect, so the decoded strobe is not used
	logic rd_en_unused;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign cmd_sio = wr_en && paddr == ADDR_CMD && pwdata[1:0] == CMD_SIO;
	assign cmd_hio = wr_en && paddr == ADDR_CMD && pwdata[1:0] == CMD_HIO;
	assign susp = state_q == STSV_SUSPENDED;
	assign timeout_hit = state_q == STSV_STORING &&
		timer_q == TW'(TIMEOUT_CYC - 1);
	assign cse_hit = (state_q == STSV_STORING || state_q == STSV_TABLING) &&
		buffered_word_service_error[sel_ch_q];
	assign err_hit = state_q == STSV_TABLING &&
		(tabling_error.interrupt_data_error_flag || tabling_error.interrupt_word_error_flag || tabling_error.status_table_fault_flag);
	assign any_err = timeout_hit || cse_hit || err_hit ||
		(tabling_error.mck && !susp);
	// Trace needs bit 0 set and a port other than the excluded one
	assign trace_ok = ctrl_q[TRACE_BIT_POS] &&
		pwdata[15:8] != EXCL_PORT_ADDR;

	// Lowest index wins; the fine arbitration lives with the channels
	always_comb begin
		pick = '0;
		pick_ok = 1'b0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (status_request[i]) begin
				pick = CHW'(i);
				pick_ok = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= STSV_IDLE;
		end else if (any_err || (cmd_hio && !susp)) begin
			state_q <= STSV_SUSPENDED;
		end else begin
			case (state_q)
				STSV_IDLE: begin
					// Requests are not looked at while suspended
					if (pick_ok)
						state_q <= STSV_STORING;
				end
				STSV_STORING: begin
					if (store_done[sel_ch_q])
						state_q <= STSV_TABLING;
				end
				STSV_TABLING: begin
					if (unit_done)
						state_q <= STSV_IDLE;
				end
				STSV_SUSPENDED: begin
					if (cmd_sio)
						state_q <= STSV_IDLE;
				end
				default: state_q <= STSV_IDLE;
			endcase
		end
	end

	// Timer only counts in the storing state, so it restarts per selection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			timer_q <= '0;
		else if (state_q == STSV_STORING && !store_done[sel_ch_q])
			timer_q <= timer_q + TW'(1);
		else
			timer_q <= '0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sel_ch_q <= '0;
		else if (state_q == STSV_IDLE && pick_ok)
			sel_ch_q <= pick;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			channel_grant <= '0;
		else if (state_q == STSV_IDLE && pick_ok && !any_err)
			channel_grant <= NUM_CH'(1) << pick;
		else if (state_q == STSV_SUSPENDED || any_err || unit_done)
			channel_grant <= '0;
	end

	// Selective reset is a one-cycle pulse; the channel then drops this status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			selective_channel_reset <= '0;
		else if (timeout_hit)
			selective_channel_reset <= NUM_CH'(1) << sel_ch_q;
		else
			selective_channel_reset <= '0;
	end

	// Service word: flags are sticky until cancellation clears them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			service_q <= '0;
		end else if (any_err) begin
			service_q[SW_CH_LSB +: 4] <= 4'(sel_ch_q);
			if (timeout_hit)
				service_q[SW_CTO] <= 1'b1;
			if (cse_hit)
				service_q[SW_CSE] <= 1'b1;
			if (err_hit) begin
				service_q[SW_IDE] <= tabling_error.interrupt_data_error_flag;
				service_q[SW_IWE] <= tabling_error.interrupt_word_error_flag;
				service_q[SW_STF] <= tabling_error.status_table_fault_flag;
			end
			if (tabling_error.mck)
				service_q[SW_MCK] <= 1'b1;
			service_q[SW_SUSP] <= 1'b1;
		end else if (cmd_hio && !susp) begin
			service_q[SW_SUSP] <= 1'b1;
		end else if (susp && cmd_sio) begin
			service_q <= '0;
		end
	end

	// Command result: condition code in [1:0]; word bits 24..31 cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_q <= '0;
		end else if (cmd_sio) begin
			result_q[31:24] <= 8'h00;
			result_q[15:8] <= susp ? 8'h00 : pwdata[15:8];
			result_q[1:0] <= susp ? CC_ACCEPT : CC_REJECT;
		end else if (cmd_hio) begin
			result_q[31:24] <= 8'h00;
			result_q[15:8] <= 8'h00;
			result_q[1:0] <= susp ? CC_REJECT : CC_ACCEPT;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_q <= CTRL_RESET;
		else if (wr_en && paddr == ADDR_CTRL)
			ctrl_q <= pwdata;
	end

	// Trace word: one word for a plain trace, three on interface timeout
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trace_q <= '0;
			trace_store <= 1'b0;
			trace_words <= 2'h0;
		end else if (cmd_sio && interface_timeout) begin
			trace_q <= {16'h0000, pwdata[15:8], 6'h00,
				susp ? CC_ACCEPT : CC_REJECT};
			trace_store <= 1'b1;
			trace_words <= 2'(MAX_UNIT_WORDS);
		end else if (cmd_sio && trace_ok) begin
			trace_q <= {16'h0000, pwdata[15:8], 6'h00,
				susp ? CC_ACCEPT : CC_REJECT};
			trace_store <= 1'b1;
			trace_words <= 2'h1;
		end else begin
			trace_store <= 1'b0;
		end
	end

	// Word count holds when a unit would pass the limit; a unit above three words is clipped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			words_q <= '0;
		else if (susp && cmd_sio)
			words_q <= '0;
		else if (state_q == STSV_TABLING && unit_done &&
			32'(words_q) + 32'(words_in_unit) <= WORD_LIMIT)
			words_q <= words_q + 14'(words_in_unit > 2'(MAX_UNIT_WORDS) ?
				2'(MAX_UNIT_WORDS) : words_in_unit);
	end

	// Interrupt on error suspension (not halt-I/O), on stored words, and on timeout traces
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tabler_irq <= 1'b0;
		else if (any_err || (cmd_sio && interface_timeout))
			tabler_irq <= 1'b1;
		else if (state_q == STSV_TABLING && unit_done)
			tabler_irq <= 1'b1;
		else if (wr_en && paddr == ADDR_SERVICE)
			tabler_irq <= 1'b0;
	end

	always_comb begin
		case (paddr)
			ADDR_CTRL: word_d = ctrl_q;
			ADDR_SERVICE: word_d = service_q;
			ADDR_RESULT: word_d = result_q;
			ADDR_TRACE: word_d = trace_q;
			ADDR_WORDS: word_d = {18'h00000, words_q};
			default: word_d = 32'h00000000;
		endcase
	end

	// Registered zero-wait answer: data lands during the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && paddr != ADDR_CTRL &&
				paddr != ADDR_SERVICE && paddr != ADDR_CMD &&
				paddr != ADDR_RESULT && paddr != ADDR_TRACE &&
				paddr != ADDR_WORDS;
			if (psel && !penable)
				prdata <= word_d;
		end
	end
	assign rd_en_unused = rd_en;
endmodule
`default_nettype wire

// ---- stsv_pkg.sv ----
// Package for the status tabler supervisor: constants, types, register map
package stsv_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int STORE_TIMEOUT_MS = 4;
	localparam int STORE_TIMEOUT_CYC = (CLK_HZ / 1000) * STORE_TIMEOUT_MS;
	localparam int MAX_TABLE_WORDS = 16383;
	localparam int MAX_UNIT_WORDS = 3;
	localparam int TRACE_BIT_POS = 0;
	localparam logic [7:0] EXCL_PORT_ADDR = 8'hFF;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_SERVICE = 12'h004;
	localparam logic [11:0] ADDR_CMD = 12'h008;
	localparam logic [11:0] ADDR_RESULT = 12'h00C;
	localparam logic [11:0] ADDR_TRACE = 12'h010;
	localparam logic [11:0] ADDR_WORDS = 12'h014;
	localparam logic [31:0] CTRL_RESET = 32'h00000000;
	localparam logic [1:0] CC_ACCEPT = 2'h0;
	localparam logic [1:0] CC_REJECT = 2'h3;
	localparam int SW_CH_LSB = 0;
	localparam int SW_CTO = 8;
	localparam int SW_CSE = 9;
	localparam int SW_IDE = 10;
	localparam int SW_IWE = 11;
	localparam int SW_STF = 12;
	localparam int SW_MCK = 13;
	localparam int SW_SUSP = 31;
	localparam logic [1:0] CMD_NONE = 2'h0;
	localparam logic [1:0] CMD_SIO = 2'h1;
	localparam logic [1:0] CMD_HIO = 2'h2;

	typedef enum logic [1:0] {
		STSV_IDLE,
		STSV_STORING,
		STSV_TABLING,
		STSV_SUSPENDED
	} stsv_state_t;

	typedef struct packed {
		logic interrupt_data_error_flag;
		logic interrupt_word_error_flag;
		logic status_table_fault_flag;
		logic mck;
	} stsv_err_t;
endpackage

// ---- stsv_props.sv ----
// Port checker for the status tabler supervisor
`timescale 1ns/10ps
`default_nettype none
module stsv_props
	import stsv_pkg::*;
#(
	parameter int NUM_CH = 4,
	parameter int TIMEOUT_CYC = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [NUM_CH-1:0] status_request,
	input wire logic [NUM_CH-1:0] store_done,
	input wire logic [NUM_CH-1:0] channel_grant,
	input wire logic [NUM_CH-1:0] selective_channel_reset,
	input wire logic tabler_irq,
	input wire logic trace_store,
	input wire logic [1:0] trace_words
);
	logic [31:0] wait_q;
	logic [7:0] dev_q;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Saturates so a stuck grant cannot wrap the count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q <= '0;
		end else if (channel_grant == '0 || (channel_grant & store_done) != '0) begin
			wait_q <= '0;
		end else if (wait_q < TIMEOUT_CYC + 4) begin
			wait_q <= wait_q + 1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dev_q <= '0;
		end else if (psel && penable && pwrite && paddr == ADDR_CMD) begin
			dev_q <= pwdata[15:8];
		end
	end
	property p_grant_one; $onehot0(channel_grant); endproperty
	a_grant_one: assert property (p_grant_one) else $error("grant not one-hot");
	property p_grant_req;
		(channel_grant & ~$past(channel_grant)) != '0 |->
			($past(status_request) & channel_grant) != '0;
	endproperty
	a_grant_req: assert property (p_grant_req) else $error("grant without request");
	property p_scr_one; $onehot0(selective_channel_reset); endproperty
	a_scr_one: assert property (p_scr_one) else $error("reset not one-hot");
	property p_scr_pulse; |selective_channel_reset |=> selective_channel_reset == '0; endproperty
	a_scr_pulse: assert property (p_scr_pulse) else $error("reset too long");
	property p_scr_chan;
		|selective_channel_reset |-> (selective_channel_reset & $past(channel_grant)) != '0;
	endproperty
	a_scr_chan: assert property (p_scr_chan) else $error("reset wrong channel");
	property p_scr_irq; |selective_channel_reset |-> ##[0:2] tabler_irq; endproperty
	a_scr_irq: assert property (p_scr_irq) else $error("no irq on timeout");
	property p_late;
		wait_q == TIMEOUT_CYC - 3 |-> ##[1:5] (|selective_channel_reset || wait_q == 0);
	endproperty
	a_late: assert property (p_late) else $error("store timeout missed");
	property p_early; |selective_channel_reset |-> wait_q >= TIMEOUT_CYC - 3; endproperty
	a_early: assert property (p_early) else $error("store timeout early");
	property p_trace_words; trace_store |-> trace_words inside {2'h1, 2'h3}; endproperty
	a_trace_words: assert property (p_trace_words) else $error("bad trace length");
	property p_trace_port; trace_store |-> dev_q != EXCL_PORT_ADDR; endproperty
	a_trace_port: assert property (p_trace_port) else $error("excluded port traced");
endmodule
bind stsv_status_tabler_supervisor stsv_props #(
	.NUM_CH(NUM_CH), .TIMEOUT_CYC(TIMEOUT_CYC)
) u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.status_request(status_request), .store_done(store_done),
	.channel_grant(channel_grant),
	.selective_channel_reset(selective_channel_reset),
	.tabler_irq(tabler_irq), .trace_store(trace_store), .trace_words(trace_words)
);
`default_nettype wire

// ---- stsv_chan_model.sv ----
// Channel model: posts status, stores it after a set delay
`timescale 1ns/10ps
`default_nettype none
module stsv_chan_model #(
	parameter int NUM_CH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [NUM_CH-1:0] post,
	input wire logic [7:0] delay,
	input wire logic [NUM_CH-1:0] channel_grant,
	input wire logic [NUM_CH-1:0] selective_channel_reset,
	output logic [NUM_CH-1:0] status_request,
	output logic [NUM_CH-1:0] store_done
);
	int cnt;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_request <= '0;
			store_done <= '0;
			cnt <= 0;
		end else begin
			// A reset channel drops that status for good
			status_request <= (status_request | post) & ~selective_channel_reset & ~store_done;
			cnt <= (channel_grant == '0) ? 0 : cnt + 1;
			// Delay 8'hFF models a channel that never finishes
			store_done <= (delay != 8'hFF && cnt >= delay) ? channel_grant : '0;
		end
	end
endmodule
`default_nettype wire

// ---- stsv_status_tabler_supervisor_test.sv ----
// Testbench for the status tabler supervisor
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin \
	check_count++; \
	if ((a) !== (e)) begin \
		err_total++; \
		$display("[ERR] %s exp %0h got %0h", n, e, a); \
	end \
end
module stsv_status_tabler_supervisor_test import stsv_pkg::*;;
	localparam int NCH = 4;
	localparam int TO = 20;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, unit_done;
	logic interface_timeout, tabler_irq, trace_store, seen_q;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [NCH-1:0] status_request, store_done, chan_err, channel_grant, scr, post;
	logic [1:0] words_in_unit, trace_words, tw;
	logic [7:0] delay;
	logic [32:0] ev;
	stsv_err_t tabling_error;
	logic [32:0] exp_q[$];
	logic [1:0] trc_q[$];
	int err_total, check_count, seed, n;
	stsv_status_tabler_supervisor #(.NUM_CH(NCH), .TIMEOUT_CYC(TO)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .status_request(status_request),
		.store_done(store_done), .buffered_word_service_error(chan_err),
		.tabling_error(tabling_error), .words_in_unit(words_in_unit),
		.unit_done(unit_done), .interface_timeout(interface_timeout),
		.channel_grant(channel_grant), .selective_channel_reset(scr),
		.tabler_irq(tabler_irq), .trace_store(trace_store), .trace_words(trace_words)
	);
	stsv_chan_model #(.NUM_CH(NCH)) u_chan (
		.pclk(pclk), .presetn(presetn), .post(post), .delay(delay),
		.channel_grant(channel_grant), .selective_channel_reset(scr),
		.status_request(status_request), .store_done(store_done)
	);
	always #20 pclk = ~pclk;
	// One unit per finished store keeps the tabling side moving
	always @(posedge pclk) begin
		seen_q <= |(store_done & channel_grant);
		unit_done <= |(store_done & channel_grant) && !seen_q;
		words_in_unit <= 2'($unsigned($random(seed)) % 3) + 2'h1;
	end
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			ev = exp_q.pop_front();
			`CHK("prdata", ev, {pslverr, prdata})
		end
		if (trace_store === 1'b1) begin
			tw = trc_q.pop_front();
			`CHK("trace_words", tw, trace_words)
		end
	end
	task automatic apb(logic wr, logic [11:0] a, logic [32:0] d);
		int w = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d[31:0];
		if (!wr) exp_q.push_back(d);
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(negedge pclk);
			w++;
		end while (pready !== 1'b1 && w < 50);
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic cmd(logic [1:0] op, logic [7:0] dv, logic [1:0] cc);
		logic [7:0] dx;
		// A rejected start-I/O keeps its device address in the result
		dx = (op == CMD_SIO && cc == CC_REJECT) ? dv : 8'h00;
		apb(1'b1, ADDR_CMD, {17'h0, dv, 6'h0, op});
		apb(1'b0, ADDR_RESULT, {17'h0, dx, 6'h0, cc});
	endtask
	task automatic hold_for(int ch);
		n = 0;
		while (channel_grant[ch] !== 1'b1 && n < 100) begin
			@(negedge pclk);
			n++;
		end
		`CHK("grant", 1'b1, channel_grant[ch])
		@(posedge pclk);
	endtask
	task automatic send(logic [NCH-1:0] p, logic [7:0] dl);
		delay <= dl;
		post <= p;
		@(posedge pclk);
		post <= '0;
	endtask
	task automatic wrap_up();
		`CHK("reads left", 0, exp_q.size())
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		wrap_up();
	end
	initial begin
		seed = 32'h8978BED1;
		{pclk, presetn, psel, penable, pwrite, interface_timeout, unit_done} = '0;
		{paddr, pwdata, chan_err, post, delay, seen_q} = '0;
		tabling_error = '0;
		err_total = 0;
		check_count = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, ADDR_CTRL, {1'b0, CTRL_RESET});
		apb(1'b0, ADDR_SERVICE, 33'h0);
		apb(1'b0, 12'hFFC, 33'h100000000);
		cmd(CMD_HIO, 8'h00, CC_ACCEPT);
		apb(1'b0, ADDR_SERVICE, 33'h1 << SW_SUSP);
		cmd(CMD_HIO, 8'h00, CC_REJECT);
		cmd(CMD_SIO, 8'h00, CC_ACCEPT);
		apb(1'b0, ADDR_SERVICE, 33'h0);
		cmd(CMD_SIO, 8'h00, CC_REJECT);
		$display("command test done");
		apb(1'b1, ADDR_CTRL, 33'h1);
		for (int k = 0; k < 3; k++) begin
			interface_timeout <= (k == 2);
			if (k != 1) trc_q.push_back((k == 2) ? 2'h3 : 2'h1);
			cmd(CMD_SIO, (k == 1) ? EXCL_PORT_ADDR : 8'($random(seed)) & 8'h7F, CC_REJECT);
			repeat (4) @(negedge pclk);
			`CHK("trace left", 0, trc_q.size())
			`CHK("irq", k == 2, tabler_irq)
			@(posedge pclk);
			apb(1'b1, ADDR_SERVICE, 33'h0);
		end
		interface_timeout <= 1'b0;
		apb(1'b1, ADDR_CTRL, 33'h0);
		$display("trace test done");
		for (int k = 0; k < 5; k++) begin
			send(NCH'(1) << (k % NCH), 8'd12);
			hold_for(k % NCH);
			apb(1'b1, ADDR_SERVICE, 33'h0);
			if (k == 0) chan_err <= NCH'(1);
			else tabling_error <= stsv_err_t'(4'(8 >> (k - 1)));
			// Table faults count only while tabling, so hold until suspended
			n = 0;
			while (tabler_irq !== 1'b1 && n < 50) begin
				@(posedge pclk);
				n++;
			end
			chan_err <= '0;
			tabling_error <= '0;
			apb(1'b0, ADDR_SERVICE, (33'h1 << SW_SUSP) | (33'h1 << (SW_CSE + k)) | 33'(k % NCH));
			`CHK("irq", 1'b1, tabler_irq)
			cmd(CMD_SIO, 8'h00, CC_ACCEPT);
		end
		repeat (30) @(posedge pclk);
		$display("error test done");
		apb(1'b1, ADDR_SERVICE, 33'h0);
		send(4'b0010, 8'hFF);
		n = 0;
		while (scr == '0 && n < 200) begin
			@(negedge pclk);
			n++;
		end
		`CHK("reset chan", 4'b0010, scr)
		`CHK("timeout span", 1'b1, n > TO - 4 && n < TO + 4)
		@(posedge pclk);
		apb(1'b0, ADDR_SERVICE, (33'h1 << SW_SUSP) | (33'h1 << SW_CTO) | 33'h1);
		`CHK("irq", 1'b1, tabler_irq)
		send(4'b0001, 8'd3);
		repeat (10) @(negedge pclk);
		`CHK("grant held", 4'h0, channel_grant)
		@(posedge pclk);
		apb(1'b1, ADDR_SERVICE, 33'h0);
		cmd(CMD_SIO, 8'h00, CC_ACCEPT);
		hold_for(0);
		repeat (10) @(negedge pclk);
		`CHK("irq tabled", 1'b1, tabler_irq)
		$display("timeout test done");
		wrap_up();
	end
endmodule
`default_nettype wire
